/* timer_defs.svh */
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// byte register addresses in the special function register space
`define T0_LOW_ADDR    8'h8A
`define T1_LOW_ADDR    8'h8B
`define T0_HIGH_ADDR   8'h8C
`define T1_HIGH_ADDR   8'h8D
`define T2_RLD_LOW_ADDR  8'hCA
`define T2_RLD_HIGH_ADDR 8'hCB
`define T2_LOW_ADDR    8'hCC
`define T2_HIGH_ADDR   8'hCD

// oscillator periods per count clock
`define TMR_OSC_DIV    12

// reset value of every byte register (not documented, chosen as zero)
`define BYTE_RESET     8'h00
// answer to a read of an address outside this block
`define UNMAPPED_DATA  8'h00
// prescaler start value
`define PRESC_RESET    4'h0
// one count step
`define COUNT_STEP     16'h0001

`endif

/* timer_pkg.sv */
package timer_pkg;

  // count source of one timer
  typedef enum logic {
    FUNC_TIMER   = 1'b0,
    FUNC_COUNTER = 1'b1
  } func_t;

  // one processor access on the special function register port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfr_req_t;

  // run and function bits shared by timers 0 and 1
  typedef struct packed {
    logic  run0;
    func_t func0;
    logic  run1;
    func_t func1;
  } timer01_ctrl_t;

  // run and function bits dedicated to timer 2
  typedef struct packed {
    logic  run2;
    func_t func2;
  } timer2_ctrl_t;

endpackage : timer_pkg

/* timer_counter_timebase.sv */
// What this block does
// RQ1: three independent 16-bit timers or event counters
// RQ2: timer function counts once per twelve oscillator periods
// RQ3: timebase from raw oscillator, never from prescaled clock
// RQ4: counter function counts falling edges of own input
// RQ5: count inputs sampled once per twelve oscillator periods
// RQ6: increment in third sample period after falling edge
// RQ7: source holds each level one full sample period
// RQ8: shared control for timers 0/1, own for 2
// RQ9: timers 0 and 1 expose high and low bytes
// RQ10: timer 0/1 bytes double as counter or holders
// RQ11: timer 2 count bytes at two adjacent addresses
// RQ12: timer 2 has capture/reload byte pair
// RQ13: byte write lands on next count clock; reads clean
`timescale 1ns/10ps
`default_nettype none
`include "timer_defs.svh"

module timer_counter_timebase #(
  parameter int OSC_DIV = `TMR_OSC_DIV
) (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst,
  // special function register port
  input  wire timer_pkg::sfr_req_t      sfr_req,
  output var  logic [7:0]               sfr_rdata,
  output var  logic                     sfr_rvalid,
  // control bits from the control registers
  input  wire timer_pkg::timer01_ctrl_t timer_ctrl01,
  input  wire timer_pkg::timer2_ctrl_t  timer2_ctrl,
  // external count inputs
  input  wire logic                     counter0_input,
  input  wire logic                     counter1_input,
  input  wire logic                     timer2_count_input,
  // live count values and timebase pulse
  output var  logic [15:0]              timer0_count,
  output var  logic [15:0]              timer1_count,
  output var  logic [15:0]              timer2_count,
  output var  logic                     count_clock
);

  // entries 0..2 are the counters, entry 3 is the timer 2 reload word
  localparam int NUM_WORDS  = 4;
  localparam int NUM_TIMERS = 3;
  localparam int RLD_IDX    = 3;

  // prescaler is four bits wide
  if (OSC_DIV < 2 || OSC_DIV > 16) begin : g_bad_div
    $error("OSC_DIV must lie between 2 and 16");
  end

  // last prescaler value, sized to the prescaler
  localparam logic [3:0] PRESC_LAST = 4'(OSC_DIV - 1);

  // byte addresses per entry, low and high
  localparam logic [7:0] LO_ADDR [0:NUM_WORDS-1] = '{
    `T0_LOW_ADDR, `T1_LOW_ADDR, `T2_LOW_ADDR, `T2_RLD_LOW_ADDR};
  localparam logic [7:0] HI_ADDR [0:NUM_WORDS-1] = '{
    `T0_HIGH_ADDR, `T1_HIGH_ADDR, `T2_HIGH_ADDR, `T2_RLD_HIGH_ADDR};

  // timebase prescaler and its terminal count
  logic [3:0]  presc_q;
  logic [3:0]  presc_d;
  logic        tick_w;
  logic        tick_q;

  // per-entry control and input views
  logic        run_w   [0:NUM_WORDS-1];
  logic        cntf_w  [0:NUM_WORDS-1];
  logic        pin_w   [0:NUM_WORDS-1];

  // per-entry state
  logic [15:0] word_q  [0:NUM_WORDS-1];   // count or reload value
  logic [15:0] word_d  [0:NUM_WORDS-1];
  logic [15:0] pend_q  [0:NUM_WORDS-1];   // bytes waiting for a tick
  logic [15:0] pend_d  [0:NUM_WORDS-1];
  logic [1:0]  pendv_q [0:NUM_WORDS-1];   // {high, low} waiting flags
  logic [1:0]  pendv_d [0:NUM_WORDS-1];
  logic        smp_q   [0:NUM_WORDS-1];   // newest input sample
  logic        old_q   [0:NUM_WORDS-1];   // sample one period earlier
  logic        inc_w   [0:NUM_WORDS-1];   // advance on this tick
  logic        wr_lo_w [0:NUM_WORDS-1];
  logic        wr_hi_w [0:NUM_WORDS-1];

  // read path
  logic [7:0]  rdata_w;
  logic [7:0]  rdata_q;
  logic        rvalid_q;

  // control fan-out: timers 0/1 from the shared pair, timer 2 its own
  assign run_w[0]  = timer_ctrl01.run0;                        // [RQ8]
  assign cntf_w[0] = (timer_ctrl01.func0 == timer_pkg::FUNC_COUNTER);
  assign run_w[1]  = timer_ctrl01.run1;                        // [RQ8]
  assign cntf_w[1] = (timer_ctrl01.func1 == timer_pkg::FUNC_COUNTER);
  assign run_w[2]  = timer2_ctrl.run2;                         // [RQ8]
  assign cntf_w[2] = (timer2_ctrl.func2 == timer_pkg::FUNC_COUNTER);
  // the reload word never counts
  assign run_w[RLD_IDX]  = 1'b0;
  assign cntf_w[RLD_IDX] = 1'b0;

  // each counter watches its own pin
  assign pin_w[0]       = counter0_input;                      // [RQ4]
  assign pin_w[1]       = counter1_input;                      // [RQ4]
  assign pin_w[2]       = timer2_count_input;                  // [RQ4]
  assign pin_w[RLD_IDX] = 1'b0;

  // divide the raw oscillator by twelve; mclk is the oscillator itself,
  // so cpu prescaling and bus stalls cannot reach this count
  assign tick_w  = (presc_q == PRESC_LAST);                    // [RQ2] [RQ3]
  assign presc_d = tick_w ? `PRESC_RESET : presc_q + 4'h1;

  // prescaler and registered tick
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      presc_q <= `PRESC_RESET;
      tick_q  <= 1'b0;
    end else begin
      presc_q <= presc_d;
      tick_q  <= tick_w;
    end
  end

  genvar gi;
  for (gi = 0; gi < NUM_WORDS; gi++) begin : g_word
    // byte address decode for writes
    assign wr_lo_w[gi] = sfr_req.wr &&
                         (sfr_req.addr == LO_ADDR[gi]);        // [RQ9] [RQ11]
    assign wr_hi_w[gi] = sfr_req.wr &&
                         (sfr_req.addr == HI_ADDR[gi]);        // [RQ9] [RQ12]

    // one count step: every tick as timer, or after a sampled 1-to-0;
    // old=1, smp=0 were taken in periods one and two, this is period three
    assign inc_w[gi] = run_w[gi] &&
                       (!cntf_w[gi] ||
                        (old_q[gi] && !smp_q[gi]));            // [RQ4] [RQ6]

    // a write arriving in a tick cycle waits for the following tick,
    // so a byte never slips in between sample and increment
    assign pendv_d[gi] = (tick_w ? 2'b00 : pendv_q[gi]) |
                         {wr_hi_w[gi], wr_lo_w[gi]};           // [RQ13]
    assign pend_d[gi]  = {wr_hi_w[gi] ? sfr_req.wdata
                                      : pend_q[gi][15:8],
                          wr_lo_w[gi] ? sfr_req.wdata
                                      : pend_q[gi][7:0]};

    // at a tick a pending byte replaces the count and skips the step;
    // otherwise all 16 bits advance together
    assign word_d[gi] =
      !tick_w           ? word_q[gi] :
      (|pendv_q[gi])    ? {pendv_q[gi][1] ? pend_q[gi][15:8]
                                          : word_q[gi][15:8],
                           pendv_q[gi][0] ? pend_q[gi][7:0]
                                          : word_q[gi][7:0]} : // [RQ13]
      inc_w[gi]         ? word_q[gi] + `COUNT_STEP :           // [RQ1] [RQ10]
                          word_q[gi];

    // word, pending bytes and input samples
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        word_q[gi]  <= {`BYTE_RESET, `BYTE_RESET};
        pend_q[gi]  <= {`BYTE_RESET, `BYTE_RESET};
        pendv_q[gi] <= 2'b00;
        smp_q[gi]   <= 1'b1;
        old_q[gi]   <= 1'b1;
      end else begin
        word_q[gi]  <= word_d[gi];
        pend_q[gi]  <= pend_d[gi];
        pendv_q[gi] <= pendv_d[gi];
        // one sample per twelve periods; a level shorter than that
        // may be missed entirely
        if (tick_w) begin
          smp_q[gi] <= pin_w[gi];                              // [RQ5] [RQ7]
          old_q[gi] <= smp_q[gi];                              // [RQ5]
        end
      end
    end
  end

  // read mux: current byte, no side effect; unmapped reads give zero
  always_comb begin
    rdata_w = `UNMAPPED_DATA;
    for (int i = 0; i < NUM_WORDS; i++) begin
      if (sfr_req.addr == LO_ADDR[i]) begin
        rdata_w = word_q[i][7:0];                              // [RQ13]
      end
      if (sfr_req.addr == HI_ADDR[i]) begin
        rdata_w = word_q[i][15:8];                             // [RQ13]
      end
    end
  end

  // registered read answer, one cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q  <= `UNMAPPED_DATA;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= sfr_req.rd;
      if (sfr_req.rd) begin
        rdata_q <= rdata_w;
      end
    end
  end

  // outputs come straight from flip-flops
  assign sfr_rdata    = rdata_q;
  assign sfr_rvalid   = rvalid_q;
  assign timer0_count = word_q[0];
  assign timer1_count = word_q[1];
  assign timer2_count = word_q[2];
  assign count_clock  = tick_q;

endmodule : timer_counter_timebase

`default_nettype wire

/* timer_counter_timebase_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module timer_counter_timebase_monitor #(
  parameter int OSC_DIV = 12
) (
  // clock and reset
  input wire logic                mclk,
  input wire logic                rst,
  // register port
  input wire timer_pkg::sfr_req_t sfr_req,
  input wire logic [7:0]          sfr_rdata,
  input wire logic                sfr_rvalid,
  // counts and timebase
  input wire logic [15:0]         timer0_count,
  input wire logic [15:0]         timer1_count,
  input wire logic [15:0]         timer2_count,
  input wire logic                count_clock
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // all three words, so one check covers every counter
  wire [47:0] all_cnt = {timer0_count, timer1_count, timer2_count};
  tick_period_a: assert property (count_clock |-> ##OSC_DIV count_clock)
    else $error("count clock period wrong");
  tick_gap_a: assert property (count_clock |=> !count_clock [*8])
    else $error("count clock pulse too early");
  cnt_at_tick_a: assert property (!count_clock |-> $stable(all_cnt))
    else $error("count moved off the timebase");
  rd_answer_a: assert property (sfr_req.rd |=> sfr_rvalid)
    else $error("read without answer");
  rd_quiet_a: assert property (!sfr_req.rd |=> !sfr_rvalid)
    else $error("answer without read");
  rdata_hold_a: assert property (!sfr_rvalid |-> $stable(sfr_rdata))
    else $error("read data moved");
  unmapped_rd_a: assert property (sfr_req.rd && sfr_req.addr == 8'h00
    |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  t2_low_rd_a: assert property (sfr_req.rd && sfr_req.addr == 8'hCC
    ##1 !count_clock |-> sfr_rdata == $past(timer2_count[7:0]))
    else $error("timer2 low byte read wrong");
  t1_high_rd_a: assert property (sfr_req.rd && sfr_req.addr == 8'h8D
    ##1 !count_clock |-> sfr_rdata == $past(timer1_count[15:8]))
    else $error("timer1 high byte read wrong");
endmodule : timer_counter_timebase_monitor
bind timer_counter_timebase timer_counter_timebase_monitor #(
  .OSC_DIV(OSC_DIV)) u_mon (.mclk(mclk), .rst(rst), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
  .timer0_count(timer0_count), .timer1_count(timer1_count),
  .timer2_count(timer2_count), .count_clock(count_clock));
`default_nettype wire

/* count_source.sv */
`timescale 1ns/10ps
`default_nettype none
// external event source on a count pin
module count_source (
  // clock
  input  wire logic       mclk,
  // pattern control
  input  wire logic       en,
  input  wire logic [7:0] hold,
  // count pin
  output var  logic       pin
);
  logic [7:0] cnt_q; // cycles spent at this level
  // each level lasts hold cycles; 12 or more is sampled at least once
  always @(negedge mclk) begin
    if (!en) begin // idle pin rests high, so no stray fall
      pin <= 1'b1;
      cnt_q <= 8'h00;
    end else if (cnt_q == hold - 8'h01) begin
      pin <= ~pin;
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : count_source
`default_nettype wire

/* timer_counter_timebase_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module timer_counter_timebase_tb_top;
  logic                     mclk, rst;      // clock and reset
  timer_pkg::sfr_req_t      req;            // register access
  timer_pkg::timer01_ctrl_t c01;            // run/function, timers 0 and 1
  timer_pkg::timer2_ctrl_t  c2;             // run/function, timer 2
  logic                     src_en, pin;    // event source, timers 1/2
  logic                     src0_en, pin0;  // event source, timer 0
  logic [7:0]               rdata, hold;
  logic                     rvalid, cclk;
  logic [15:0]              cnt0, cnt1, cnt2;
  int                       error_cnt, cmp_count;
  logic [7:0] adr [9] = '{8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hCA, 8'hCB,
                          8'hCC, 8'hCD, 8'h00};
  // one source feeds the timer 1 and timer 2 count pins
  count_source u_src (.mclk(mclk), .en(src_en), .hold(hold), .pin(pin));
  // timer 0 gets its own pin, so a crossed pin mapping shows up
  count_source u_src0 (.mclk(mclk), .en(src0_en), .hold(hold), .pin(pin0));
  timer_counter_timebase u_dut (.mclk(mclk), .rst(rst), .sfr_req(req),
    .sfr_rdata(rdata), .sfr_rvalid(rvalid), .timer_ctrl01(c01),
    .timer2_ctrl(c2), .counter0_input(pin0), .counter1_input(pin),
    .timer2_count_input(pin), .timer0_count(cnt0), .timer1_count(cnt1),
    .timer2_count(cnt2), .count_clock(cclk));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // wait n count clock pulses, end on a falling edge
  task automatic ticks(input int n);
    repeat (n) @(posedge mclk iff cclk);
    @(negedge mclk);
  endtask : ticks
  // one access; caller releases the port after the last one
  task automatic sfr(input logic w, input logic [7:0] a, d,
                     output logic [7:0] q);
    req = '{addr: a, wdata: d, wr: w, rd: ~w};
    @(negedge mclk);
    q = rdata;
    if (!w) chk({15'h0000, rvalid}, 16'h0001);
  endtask : sfr
  // timers 1 and 2 count fastest falls; timer 0 sees a quiet pin
  task automatic t_counter;
    c01 = 4'hF; // all running in counter function
    c2 = 2'h3;
    ticks(1);
    src_en = 1'b1; // one level per sample period, five falls
    repeat (120) @(negedge mclk);
    src_en = 1'b0;
    ticks(3); // increment lands two samples after the fall
    chk(cnt1, 16'h0005);
    chk(cnt2, 16'h0005);
    chk(cnt0, 16'h0000);
  endtask : t_counter
  // timer 0 counts its own pin, then a reset in mid-run
  task automatic t_pin0_reset;
    c01 = 4'hC; // run0 in counter function only
    c2 = 2'h0;
    ticks(1);
    src0_en = 1'b1; // two falls
    repeat (48) @(negedge mclk);
    src0_en = 1'b0;
    ticks(3);
    chk(cnt0, 16'h7377);
    chk(cnt1, 16'h7274);
    c01 = 4'h0;
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    chk(cnt0, 16'h0000);
    chk(cnt1, 16'h0000);
    chk(cnt2, 16'h0000);
    chk({8'h00, rdata}, 16'h0000);
    rst = 1'b0;
    repeat (11) @(negedge mclk);
    chk({15'h0000, cclk}, 16'h0000);
    @(negedge mclk);
    chk({15'h0000, cclk}, 16'h0001);
  endtask : t_pin0_reset
  // all three in timer function for seven ticks
  task automatic t_timer;
    ticks(1);
    c01 = 4'hA;
    c2 = 2'h2;
    ticks(7);
    c01 = 4'h0;
    c2 = 2'h0;
    ticks(2);
    chk(cnt0, 16'h0007);
    chk(cnt1, 16'h000C);
    chk(cnt2, 16'h000C);
  endtask : t_timer
  // write every byte back to back, then read all plus a hole
  task automatic t_regs;
    logic [7:0] q;
    foreach (adr[i]) sfr(1'b1, adr[i], adr[i] ^ 8'hFF, q);
    req = '0;
    ticks(2);
    chk(cnt0, 16'h7375);
    chk(cnt1, 16'h7274);
    chk(cnt2, 16'h3233);
    foreach (adr[i]) begin
      sfr(1'b0, adr[i], 8'h00, q);
      chk({8'h00, q}, {8'h00, (i < 8) ? adr[i] ^ 8'hFF : 8'h00});
    end
    req = '0;
  endtask : t_regs
  // cut a hang short well past the expected run
  initial begin
    #(8 * 3000);
    error_cnt++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    req = '0;
    c01 = 4'h0;
    c2 = 2'h0;
    src_en = 1'b0;
    src0_en = 1'b0;
    hold = 8'h0C;
    error_cnt = 0;
    cmp_count = 0;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    t_counter();
    t_timer();
    t_regs();
    t_pin0_reset();
    close_out();
  end
endmodule : timer_counter_timebase_tb_top
`default_nettype wire
